// ---- design/spi_baud_gen.v ----
`timescale 1ns/10ps
`include "spi_dma_defs.vh"
module spi_baud_gen (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [1:0] primary_divide_sel,
    input  wire [2:0] secondary_divide_sel,
    output reg        lead_tick,
    output reg        trail_tick
);
    reg  [9:0] cnt_reg;
    wire [9:0] ratio;
    wire [9:0] ratio_eff;
    wire [9:0] half;

    function [9:0] primary_ratio;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    primary_ratio = 10'h040;
                2'h1:    primary_ratio = 10'h010;
                2'h2:    primary_ratio = 10'h004;
                default: primary_ratio = 10'h001;
            endcase
        end
    endfunction

    // product of both ratios sets the period
    assign ratio     = primary_ratio(primary_divide_sel) * (10'h008 - {7'h00, secondary_divide_sel});
    assign ratio_eff = (ratio < `MIN_RATIO) ? `MIN_RATIO : ratio;
    assign half      = {1'b0, ratio_eff[9:1]};

    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_reg    <= 10'h000;
            lead_tick  <= 1'b0;
            trail_tick <= 1'b0;
        end else begin
            lead_tick  <= (cnt_reg == half - 10'h001);
            trail_tick <= (cnt_reg == ratio_eff - 10'h001);
            if (cnt_reg == ratio_eff - 10'h001) begin
                cnt_reg <= 10'h000;
            end else begin
                cnt_reg <= cnt_reg + 10'h001;
            end
        end
    end
endmodule // spi_baud_gen

// ---- design/spi_dma_defs.vh ----
`ifndef SPI_DMA_DEFS_VH
`define SPI_DMA_DEFS_VH
// Notes on behaviour
// - master serial clock is core clock divided by primary then secondary prescale fields
// - serial clock rate equals core rate over primary ratio times secondary ratio; a product of 1 gives core rate over 2
// - unframed master clocks only while shifting, exactly 8 or 16 pulses, else idle
// - framed master serial clock toggles continuously, shifting or not
// - fifo enable bit at 0 gives a single-word buffer for dma use
// - receive dma request each time a received word is ready in the buffer
// - transmit dma request after each completed transmission
// - tx-only master requests nothing until a primed first word has gone out
// - rx and tx master first request follows first reception, primed by a write
// - transmitting slave requests nothing until first word received; software preloads
// - rx-only slave requests as soon as the first word arrives, unprimed
// - deep sleep behaviour depends on master or slave role at entry
// - sleeping master resets clock divider and aborts the partial transfer for good
// - sleeping slave finishes the transfer, then sets receive full and event flag
// - idle mode halts like sleep when stop-in-idle is 1, runs when 0
// - register contents survive entry to and exit from sleep

// register byte offsets
`define OFS_STATUS        5'h00
`define OFS_CONTROL1      5'h04
`define OFS_CONTROL2      5'h08
`define OFS_BUFFER        5'h0c
`define OFS_EVENT         5'h10

// status register fields
`define ST_ENABLE         15
`define ST_STOP_IDLE      13
`define ST_RX_OVERFLOW    6
`define ST_TX_FULL        1
`define ST_RX_FULL        0

// first control register fields
`define C1_DIS_SCK        12
`define C1_DIS_SDO        11
`define C1_WIDE16         10
`define C1_SS_ENABLE      7
`define C1_CLK_POL        6
`define C1_MASTER         5
`define C1_SEC_HI         4
`define C1_SEC_LO         2
`define C1_PRI_HI         1
`define C1_PRI_LO         0

// second control register fields
`define C2_FRAMED         15
`define C2_FRAME_SLAVE    14
`define C2_FRAME_POL      13
`define C2_FIFO_EN        0

// event register field
`define EV_EVENT_FLAG     0

`define RESET_STATUS      16'h0000
`define RESET_CONTROL1    16'h0000
`define RESET_CONTROL2    16'h0000
`define RESET_BUFFER      16'h0000

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// smallest divide ratio the edge logic can realise
`define MIN_RATIO         10'h002
`endif

// ---- design/spi_dma_port.v ----
`timescale 1ns/10ps
`include "spi_dma_defs.vh"
module spi_dma_port (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        sleep_mode,
    input  wire        idle_mode,
    input  wire        serial_clock_pin_i,
    output wire        serial_clock_pin_o,
    output wire        serial_clock_pin_oe,
    input  wire        sdi_pin,
    output wire        sdo_pin_o,
    output wire        sdo_pin_oe,
    input  wire        ss_pin_i,
    output wire        ss_pin_o,
    output wire        ss_pin_oe,
    output wire        rx_dma_req,
    output wire        tx_dma_req
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers and state
    reg  [15:0] status_reg;
    reg  [15:0] first_control_reg;
    reg  [15:0] second_control_reg;
    reg  [15:0] tx_buf_reg;
    reg  [15:0] rx_buf_reg;
    reg         event_irq_flag_reg;
    reg         phase_reg;
    reg         frame_active_reg;
    reg         rx_req_reg;
    reg         tx_req_reg;
    reg  [2:0]  sck_sync_reg;
    reg  [1:0]  sdi_sync_reg;
    reg  [1:0]  ss_sync_reg;

    wire        wr_fire;
    wire        rd_fire;
    wire [2:0]  wr_index;
    wire [2:0]  rd_index;
    wire        buf_read;
    wire        buf_write;
    wire        enabled;
    wire        is_master;
    wire        framed;
    wire        frame_slave;
    wire        ckp;
    wire        halt;
    wire        master_abort;
    wire        gen_run;
    wire        gen_lead;
    wire        gen_trail;
    wire        ext_lead;
    wire        ext_trail;
    wire        ss_active;
    wire        edge_lead;
    wire        edge_trail;
    wire        load;
    wire        busy;
    wire        done;
    wire        sdo_bit;
    wire [15:0] rx_word;
    wire        rx_accept;
    wire        rx_full;
    wire        tx_full;
    wire        rx_overflow;
    reg  [15:0] rd_value;
    reg         rd_ok;

    function [15:0] merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    function mapped;
        input [2:0] index;
        begin
            mapped = (index <= 3'h4);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: write address and data taken together, one cycle answer
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_index      = s_axi_awaddr[4:2];
    assign rd_index      = s_axi_araddr[4:2];
    assign buf_write     = wr_fire && ({wr_index, 2'h0} == `OFS_BUFFER);
    assign buf_read      = rd_fire && ({rd_index, 2'h0} == `OFS_BUFFER);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wr_index) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always @* begin
        rd_value = 16'h0000;
        rd_ok    = 1'b1;
        case ({rd_index, 2'h0})
            `OFS_STATUS:   rd_value = status_reg;
            `OFS_CONTROL1: rd_value = first_control_reg;
            `OFS_CONTROL2: rd_value = second_control_reg;
            `OFS_BUFFER:   rd_value = rx_buf_reg;
            `OFS_EVENT:    rd_value = {15'h0000, event_irq_flag_reg};
            default:       rd_ok    = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_value};
            s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control decode
    assign enabled     = status_reg[`ST_ENABLE];
    assign is_master   = first_control_reg[`C1_MASTER];
    assign ckp         = first_control_reg[`C1_CLK_POL];
    assign framed      = second_control_reg[`C2_FRAMED];
    assign frame_slave = second_control_reg[`C2_FRAME_SLAVE];
    assign rx_full     = status_reg[`ST_RX_FULL];
    assign tx_full     = status_reg[`ST_TX_FULL];
    assign rx_overflow = status_reg[`ST_RX_OVERFLOW];

    // a halted slave keeps running on the outside clock
    assign halt         = sleep_mode || (idle_mode && status_reg[`ST_STOP_IDLE]);
    assign master_abort = !enabled || (is_master && halt);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; only the second stage onward is looked at
    always @(posedge aclk) begin
        if (!aresetn) begin
            sck_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
            ss_sync_reg  <= 2'h3;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_pin_i};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi_pin};
            ss_sync_reg  <= {ss_sync_reg[0], ss_pin_i};
        end
    end

    assign ext_lead  = (sck_sync_reg[1] != ckp) && (sck_sync_reg[2] == ckp);
    assign ext_trail = (sck_sync_reg[1] == ckp) && (sck_sync_reg[2] != ckp);
    assign ss_active = framed ? (ss_sync_reg[1] == second_control_reg[`C2_FRAME_POL])
                              : (!first_control_reg[`C1_SS_ENABLE] || !ss_sync_reg[1]);

    ////////////////////////////////////////////////////////////////////////////////
    // clock generation and shift engine
    // framed master clock free runs; unframed only while a word is out
    assign gen_run = enabled && is_master && !halt && (framed || busy);

    spi_baud_gen i_spi_baud_gen (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .run                  (gen_run),
        .primary_divide_sel   (first_control_reg[`C1_PRI_HI:`C1_PRI_LO]),
        .secondary_divide_sel (first_control_reg[`C1_SEC_HI:`C1_SEC_LO]),
        .lead_tick            (gen_lead),
        .trail_tick           (gen_trail)
    );

    assign edge_lead  = is_master ? gen_lead : (ext_lead && ss_active);
    assign edge_trail = is_master ? gen_trail : (ext_trail && ss_active);

    // unframed master starts on a buffer write; framed starts at an idle clock edge
    assign load = enabled && !busy && !master_abort &&
                  ((is_master && !framed && tx_full) ||
                   (is_master && framed && !frame_slave && tx_full && gen_trail) ||
                   (framed && frame_slave && ss_active && edge_trail) ||
                   (!is_master && !framed && (tx_full || edge_lead)));

    spi_shifter i_spi_shifter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .abort   (master_abort),
        .load    (load),
        .tx_word (tx_buf_reg),
        .wide16  (first_control_reg[`C1_WIDE16]),
        .lead    (edge_lead),
        .trail   (edge_trail),
        .sdi     (sdi_sync_reg[1]),
        .sdo     (sdo_bit),
        .busy    (busy),
        .done    (done),
        .rx_word (rx_word)
    );

    always @(posedge aclk) begin
        if (!aresetn || !gen_run) begin
            phase_reg <= 1'b0;
        end else if (gen_lead) begin
            phase_reg <= 1'b1;
        end else if (gen_trail) begin
            phase_reg <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || master_abort) begin
            frame_active_reg <= 1'b0;
        end else if (load && framed && !frame_slave) begin
            frame_active_reg <= 1'b1;
        end else if (edge_trail) begin
            frame_active_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; sleep never touches them
    // received words are dropped while the overflow flag stands
    assign rx_accept = done && !rx_overflow && (!rx_full || buf_read);

    always @(posedge aclk) begin
        if (!aresetn) begin
            status_reg         <= `RESET_STATUS;
            first_control_reg  <= `RESET_CONTROL1;
            second_control_reg <= `RESET_CONTROL2;
            tx_buf_reg         <= `RESET_BUFFER;
            rx_buf_reg         <= `RESET_BUFFER;
            event_irq_flag_reg <= 1'b0;
        end else begin
            if (wr_fire && {wr_index, 2'h0} == `OFS_CONTROL1) begin
                first_control_reg <= merge(first_control_reg, s_axi_wdata, s_axi_wstrb)
                                     & 16'h1fff;
            end
            if (wr_fire && {wr_index, 2'h0} == `OFS_CONTROL2) begin
                // single-word buffer either way; the bit is kept for software
                second_control_reg <= merge(second_control_reg, s_axi_wdata, s_axi_wstrb)
                                      & 16'he001;
            end
            if (wr_fire && {wr_index, 2'h0} == `OFS_STATUS && s_axi_wstrb[1]) begin
                status_reg[`ST_ENABLE]    <= s_axi_wdata[`ST_ENABLE];
                status_reg[`ST_STOP_IDLE] <= s_axi_wdata[`ST_STOP_IDLE];
            end
            // overflow: software clears by writing 0; a new overflow wins over a clear in the same cycle
            if (done && !rx_accept && !rx_overflow) begin
                status_reg[`ST_RX_OVERFLOW] <= 1'b1;
            end else if (wr_fire && {wr_index, 2'h0} == `OFS_STATUS && s_axi_wstrb[0] &&
                         !s_axi_wdata[`ST_RX_OVERFLOW]) begin
                status_reg[`ST_RX_OVERFLOW] <= 1'b0;
            end
            if (buf_write) begin
                tx_buf_reg             <= merge(tx_buf_reg, s_axi_wdata, s_axi_wstrb);
                status_reg[`ST_TX_FULL] <= 1'b1;
            end else if (load) begin
                status_reg[`ST_TX_FULL] <= 1'b0;
            end
            if (rx_accept) begin
                rx_buf_reg              <= rx_word;
                status_reg[`ST_RX_FULL] <= 1'b1;
            end else if (buf_read) begin
                status_reg[`ST_RX_FULL] <= 1'b0;
            end
            if (rx_accept) begin
                event_irq_flag_reg <= 1'b1;
            end else if (wr_fire && {wr_index, 2'h0} == `OFS_EVENT && s_axi_wstrb[0] &&
                         s_axi_wdata[`EV_EVENT_FLAG]) begin
                event_irq_flag_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // dma requests: one pulse per word
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_req_reg <= 1'b0;
            tx_req_reg <= 1'b0;
        end else begin
            rx_req_reg <= rx_accept;
            tx_req_reg <= done && !first_control_reg[`C1_DIS_SDO];
        end
    end

    assign rx_dma_req = rx_req_reg;
    assign tx_dma_req = tx_req_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // pins
    assign serial_clock_pin_o  = ckp ^ phase_reg;
    assign serial_clock_pin_oe = enabled && is_master && !first_control_reg[`C1_DIS_SCK];
    assign sdo_pin_o           = busy ? sdo_bit : 1'b0;
    assign sdo_pin_oe          = enabled && !first_control_reg[`C1_DIS_SDO];
    assign ss_pin_o            = frame_active_reg ~^ second_control_reg[`C2_FRAME_POL];
    assign ss_pin_oe           = enabled && framed && !frame_slave;
endmodule // spi_dma_port

// ---- design/spi_shifter.v ----
`timescale 1ns/10ps
module spi_shifter (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        abort,
    input  wire        load,
    input  wire [15:0] tx_word,
    input  wire        wide16,
    input  wire        lead,
    input  wire        trail,
    input  wire        sdi,
    output wire        sdo,
    output reg         busy,
    output reg         done,
    output wire [15:0] rx_word
);
    reg [15:0] tx_sr_reg;
    reg [15:0] rx_sr_reg;
    reg [4:0]  count_reg;

    assign sdo     = wide16 ? tx_sr_reg[15] : tx_sr_reg[7];
    assign rx_word = wide16 ? rx_sr_reg : {8'h00, rx_sr_reg[7:0]};

    always @(posedge aclk) begin
        if (!aresetn || abort) begin
            tx_sr_reg <= 16'h0000;
            rx_sr_reg <= 16'h0000;
            count_reg <= 5'h00;
            busy      <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                tx_sr_reg <= tx_word;
                count_reg <= 5'h00;
                busy      <= 1'b1;
                // a slave armed by its first edge keeps that bit
                if (lead) begin
                    rx_sr_reg <= {rx_sr_reg[14:0], sdi};
                end
            end else if (busy) begin
                if (lead) begin
                    rx_sr_reg <= {rx_sr_reg[14:0], sdi};
                end
                if (trail) begin
                    tx_sr_reg <= {tx_sr_reg[14:0], 1'b0};
                    count_reg <= count_reg + 5'h01;
                    // 8 or 16 trailing edges end the word
                    if (count_reg == (wide16 ? 5'h0f : 5'h07)) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // spi_shifter

// ---- verification/spi_dma_port_asserts.sv ----
`timescale 1ns/10ps
module spi_dma_port_asserts (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire sleep_mode,
    input wire serial_clock_pin_o,
    input wire serial_clock_pin_oe,
    input wire rx_dma_req,
    input wire tx_dma_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg [3:0] quiet;
    // a request long after the last serial edge came without a word behind it
    always @(posedge aclk) begin
        if (!aresetn || serial_clock_pin_o != $past(serial_clock_pin_o))
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end
    sequence halted;
        (serial_clock_pin_oe && sleep_mode) [*4];
    endsequence
    AST_READY_PAIR: assert property (s_axi_awready == s_axi_wready)
        else $error("write readies split");
    AST_WRITE_RESP: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    AST_READ_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_RX_PULSE: assert property (rx_dma_req |=> !rx_dma_req)
        else $error("rx request held");
    AST_TX_PULSE: assert property (tx_dma_req |=> !tx_dma_req)
        else $error("tx request held");
    AST_RX_AFTER_WORD: assert property (rx_dma_req && serial_clock_pin_oe |-> quiet < 4'h8)
        else $error("rx request without a word");
    AST_TX_AFTER_WORD: assert property (tx_dma_req && serial_clock_pin_oe |-> quiet < 4'h8)
        else $error("tx request without a word");
    AST_HALT_QUIET: assert property (halted |-> !tx_dma_req && !rx_dma_req
        && $stable(serial_clock_pin_o)) else $error("master active while asleep");
    cover property (halted);
endmodule // spi_dma_port_asserts

bind spi_dma_port spi_dma_port_asserts i_spi_dma_port_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .sleep_mode(sleep_mode),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe(serial_clock_pin_oe),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req)
);

// ---- verification/spi_dma_port_test.sv ----
`timescale 1ns/10ps
`include "spi_dma_defs.vh"
module spi_dma_port_test;
    reg         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    reg         sleep_mode = 1'b0, idle_mode = 1'b0, load = 1'b0, wide = 1'b0, ext_sck = 1'b0;
    reg  [4:0]  awaddr = 5'h00, araddr = 5'h00;
    reg  [31:0] wdata = 32'h0;
    reg  [15:0] reply = 16'h0;
    wire        awready, wready, bvalid, arready, rvalid, rx_req, tx_req;
    wire        sck_o, sck_oe, sdi, sdo, sdo_oe, ss_o, ss_oe;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] got;
    integer     failures = 0, tests_run = 0, edges = 0, rx_cnt = 0, tx_cnt = 0, period = 0;
    time        t_last = 0;
    // no pull resistors on the link; released lines park at their idle level
    wire        sck = sck_oe ? sck_o : ext_sck;
    wire        ss_n = ss_oe ? ss_o : 1'b1;
    spi_dma_port i_spi_dma_port (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .serial_clock_pin_i(sck),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .sdi_pin(sdi),
        .sdo_pin_o(sdo), .sdo_pin_oe(sdo_oe), .ss_pin_i(ss_n), .ss_pin_o(ss_o),
        .ss_pin_oe(ss_oe), .rx_dma_req(rx_req), .tx_dma_req(tx_req));
    spi_slave_model i_spi_slave_model (.sck(sck), .sdo(sdo), .load(load), .wide16(wide),
        .reply(reply), .sdi(sdi), .got(got));
    initial begin
        forever #20 aclk = ~aclk;
    end
    always @(posedge sck) begin
        edges  = edges + 1;
        period = $time - t_last;
        t_last = $time;
    end
    always @(posedge aclk) begin
        rx_cnt = rx_cnt + rx_req;
        tx_cnt = tx_cnt + tx_req;
    end
    ////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [31:0] d, input [1:0] r);
        begin
            awaddr  <= a;
            wdata   <= d;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            do @(posedge aclk); while (!awready);
            awvalid <= 1'b0;
            wvalid  <= 1'b0;
            do @(posedge aclk); while (!bvalid);
            check(bresp, r);
        end
    endtask
    task rd(input [4:0] a, input [31:0] e, input [1:0] r);
        begin
            araddr  <= a;
            arvalid <= 1'b1;
            do @(posedge aclk); while (!arready);
            arvalid <= 1'b0;
            do @(posedge aclk); while (!rvalid);
            check(rresp, r);
            if (r == `RESP_OKAY)
                check(rdata, e);
        end
    endtask
    task xfer(input [15:0] tx, input [15:0] rx, input [31:0] ctrl, input [31:0] ratio);
        reg [15:0] mask;
        begin
            mask = ctrl[`C1_WIDE16] ? 16'hffff : 16'h00ff;
            wr(`OFS_CONTROL1, ctrl, `RESP_OKAY);
            reply <= rx;
            wide  <= ctrl[`C1_WIDE16];
            @(posedge aclk);
            load <= 1'b1;
            @(posedge aclk);
            load   <= 1'b0;
            edges  = 0;
            rx_cnt = 0;
            tx_cnt = 0;
            wr(`OFS_BUFFER, {16'h0000, tx}, `RESP_OKAY);
            while (tx_cnt == 0) @(posedge aclk);
            repeat (4) @(posedge aclk);
            check(edges, ctrl[`C1_WIDE16] ? 16 : 8);
            check(period, ratio * 40);
            check(rx_cnt * 16 + tx_cnt, 17);
            check({16'h0000, got & mask}, {16'h0000, tx & mask});
            rd(`OFS_BUFFER, {16'h0000, rx & mask}, `RESP_OKAY);
            rd(`OFS_STATUS, 32'h8000, `RESP_OKAY);
        end
    endtask
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        failures = failures + 1;
        finish_test;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`OFS_CONTROL1, 32'h0, `RESP_OKAY);
        rd(5'h14, 32'h0, `RESP_SLVERR);
        wr(5'h18, 32'h1, `RESP_SLVERR);
        wr(`OFS_CONTROL2, 32'h1, `RESP_OKAY);
        rd(`OFS_CONTROL2, 32'h1, `RESP_OKAY);
        wr(`OFS_CONTROL2, 32'h0, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h8000, `RESP_OKAY);
        wr(`OFS_CONTROL1, 32'h800, `RESP_OKAY);
        reply      <= 16'h00b4;
        sleep_mode <= 1'b1;
        load       <= 1'b1;
        @(posedge aclk);
        load <= 1'b0;
        repeat (16) begin
            repeat (6) @(posedge aclk);
            ext_sck <= ~ext_sck;
        end
        repeat (8) @(posedge aclk);
        sleep_mode <= 1'b0;
        check(rx_cnt * 16 + tx_cnt, 16);
        rd(`OFS_BUFFER, 32'hb4, `RESP_OKAY);
        edges  = 0;
        rx_cnt = 0;
        tx_cnt = 0;
        wr(`OFS_CONTROL1, 32'h3a, `RESP_OKAY);
        repeat (50) @(posedge aclk);
        check(rx_cnt + tx_cnt + edges, 0);
        xfer(16'h00a5, 16'h003c, 32'h3a, 8);
        xfer(16'hc3e1, 16'h5a96, 32'h43a, 8);
        xfer(16'h0081, 16'h007e, 32'h3d, 16);
        xfer(16'h1234, 16'hfedc, 32'h423, 8);
        edges  = 0;
        rx_cnt = 0;
        tx_cnt = 0;
        wr(`OFS_BUFFER, 32'h5555, `RESP_OKAY);
        while (edges < 3) @(posedge aclk);
        sleep_mode <= 1'b1;
        repeat (40) @(posedge aclk);
        sleep_mode <= 1'b0;
        repeat (400) @(posedge aclk);
        check(rx_cnt + tx_cnt + edges, 3);
        rd(`OFS_CONTROL1, 32'h423, `RESP_OKAY);
        xfer(16'h0f0f, 16'h7001, 32'h423, 8);
        wr(`OFS_CONTROL2, 32'h8000, `RESP_OKAY);
        edges = 0;
        repeat (200) @(posedge aclk);
        check(edges > 20, 1);
        wr(`OFS_CONTROL2, 32'h0, `RESP_OKAY);
        idle_mode <= 1'b1;
        xfer(16'h00c6, 16'h0039, 32'h3a, 8);
        wr(`OFS_STATUS, 32'ha000, `RESP_OKAY);
        edges  = 0;
        tx_cnt = 0;
        wr(`OFS_BUFFER, 32'h0099, `RESP_OKAY);
        repeat (200) @(posedge aclk);
        check(edges + tx_cnt, 0);
        finish_test;
    end
endmodule // spi_dma_port_test

// ---- verification/spi_slave_model.sv ----
`timescale 1ns/10ps
module spi_slave_model (
    input  wire        sck,
    input  wire        sdo,
    input  wire        load,
    input  wire        wide16,
    input  wire [15:0] reply,
    output wire        sdi,
    output reg  [15:0] got
);
    reg [15:0] sr = 16'h0000;
    initial got = 16'h0000;
    always @(posedge load)
        sr <= wide16 ? reply : {reply[7:0], 8'h00};
    // refill with inverted bits so a stray extra sample never looks valid
    always @(negedge sck)
        sr <= {sr[14:0], ~sr[15]};
    always @(posedge sck)
        got <= {got[14:0], sdo};
    assign sdi = sr[15];
endmodule // spi_slave_model
